// ==== rtl/tmj_pkg.sv ====
// Constants, states and chain layout for the trace register access chain
package tmj_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 7;
  localparam int CHAIN_W = 40;
  localparam int DATA_LSB = 0;
  localparam int ADDR_LSB = 32;
  localparam int RW_BIT = 39;
  localparam int IR_W = 4;
  localparam int SEL_W = 4;
  localparam logic [IR_W-1:0] INST_SCAN_N = 4'h2;
  localparam logic [IR_W-1:0] INST_INTEST = 4'hC;
  localparam logic [IR_W-1:0] INST_BYPASS = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [SEL_W-1:0] CHAIN_TRACE = 4'h6;
  localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;
  localparam logic [CHAIN_W-1:0] CHAIN_RESET = 40'h00_0000_0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAPTURE_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
    ST_EXIT2_DR, ST_UPDATE_DR, ST_SEL_IR, ST_CAPTURE_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPDATE_IR
  } tmj_tap_t;
endpackage

// ==== rtl/tmj_sync.sv ====
// Two-stage synchroniser for pin inputs
module tmj_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;
endmodule

// ==== rtl/tmj_access.sv ====
// Trace macrocell register access chain behind the test port
// Contract
// - Trace registers are reached only through the test port chain.
// - The access chain is scan chain 6 of the test port controller.
// - Chain is 40 bits: 32 data, 7 address, one read/write flag.
// - Host reads with flag zero; device ignores the data field then.
// - Read or write happens only on entering Update-DR, never while shifting.
module tmj_access
  import tmj_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trstN,
  output logic tdo,
  output logic tdoOe,
  output logic regWrStb,
  output logic regRdStb,
  output logic [ADDR_W-1:0] regAddr,
  output logic [DATA_W-1:0] regWdata,
  input wire logic [DATA_W-1:0] regRdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling and link clock edges
  logic [3:0] pinSync;
  logic tckS;
  logic tmsS;
  logic tdiS;
  logic trstS;
  logic tckDly_reg;

  tmj_sync #(.W(4)) uSync (
    .clk(clk),
    .srst(srst),
    .din({tck, tms, tdi, ~trstN}),
    .dout(pinSync)
  );

  assign tckS = pinSync[3];
  assign tmsS = pinSync[2];
  assign tdiS = pinSync[1];
  assign trstS = pinSync[0];

  always_ff @(posedge clk) begin
    if (srst) tckDly_reg <= 1'b0;
    else tckDly_reg <= tckS;
  end

  wire tckRise = tckS & ~tckDly_reg;
  wire tckFall = ~tckS & tckDly_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Test port state machine
  tmj_tap_t state_reg;
  tmj_tap_t state_next;

  always_comb begin
    case (state_reg)
      ST_RESET: state_next = tmsS ? ST_RESET : ST_IDLE;
      ST_IDLE: state_next = tmsS ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_next = tmsS ? ST_SEL_IR : ST_CAPTURE_DR;
      ST_CAPTURE_DR: state_next = tmsS ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_next = tmsS ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_next = tmsS ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: state_next = tmsS ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_next = tmsS ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR: state_next = tmsS ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_next = tmsS ? ST_RESET : ST_CAPTURE_IR;
      ST_CAPTURE_IR: state_next = tmsS ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_next = tmsS ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_next = tmsS ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: state_next = tmsS ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_next = tmsS ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR: state_next = tmsS ? ST_SEL_DR : ST_IDLE;
      default: state_next = ST_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst || trstS) state_reg <= ST_RESET;
    else if (tckRise) state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction and chain select
  logic [IR_W-1:0] irShift_reg;
  logic [IR_W-1:0] ir_reg;
  logic [SEL_W-1:0] selShift_reg;
  logic [SEL_W-1:0] chainSel_reg;
  logic bypass_reg;

  wire tapReset = srst || trstS || state_reg == ST_RESET;
  wire selPath = ir_reg == INST_SCAN_N;
  wire chainOn = ir_reg == INST_INTEST && chainSel_reg == CHAIN_TRACE;
  wire stepEn = tckRise;
  wire inCapDr = stepEn && state_reg == ST_CAPTURE_DR;
  wire inShDr = stepEn && state_reg == ST_SHIFT_DR;

  always_ff @(posedge clk) begin
    if (tapReset) begin
      irShift_reg <= IR_CAPTURE;
      ir_reg <= INST_BYPASS;
    end else if (stepEn && state_reg == ST_CAPTURE_IR) begin
      irShift_reg <= IR_CAPTURE;
    end else if (stepEn && state_reg == ST_SHIFT_IR) begin
      irShift_reg <= {tdiS, irShift_reg[IR_W-1:1]};
    end else if (stepEn && state_reg == ST_UPDATE_IR) begin
      ir_reg <= irShift_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (tapReset) begin
      selShift_reg <= SEL_RESET;
      chainSel_reg <= SEL_RESET;
    end else if (selPath && inCapDr) begin
      selShift_reg <= chainSel_reg;
    end else if (selPath && inShDr) begin
      selShift_reg <= {tdiS, selShift_reg[SEL_W-1:1]};
    end else if (selPath && stepEn && state_reg == ST_UPDATE_DR) begin
      chainSel_reg <= selShift_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (tapReset) bypass_reg <= 1'b0;
    else if (inCapDr) bypass_reg <= 1'b0;
    else if (inShDr) bypass_reg <= tdiS;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access chain: data low, address above, flag on top
  logic [CHAIN_W-1:0] chain_reg;
  logic [DATA_W-1:0] rdHold_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      chain_reg <= CHAIN_RESET;
    end else if (chainOn && inCapDr) begin
      chain_reg <= {chain_reg[CHAIN_W-1:ADDR_LSB], rdHold_reg};
    end else if (chainOn && inShDr) begin
      chain_reg <= {tdiS, chain_reg[CHAIN_W-1:1]};
    end
  end

  wire rwFlag = chain_reg[RW_BIT];
  wire [ADDR_W-1:0] chainAddr = chain_reg[ADDR_LSB +: ADDR_W];
  wire [DATA_W-1:0] chainData = chain_reg[DATA_LSB +: DATA_W];
  // Only path to the registers, fired on entry to Update-DR
  wire accessGo = chainOn && stepEn && state_next == ST_UPDATE_DR && !tapReset;

  always_ff @(posedge clk) begin
    if (srst) begin
      regWrStb <= 1'b0;
      regRdStb <= 1'b0;
      regAddr <= ADDR_RESET;
      regWdata <= DATA_RESET;
    end else begin
      regWrStb <= accessGo && rwFlag;
      regRdStb <= accessGo && !rwFlag;
      if (accessGo) begin
        regAddr <= chainAddr;
        regWdata <= rwFlag ? chainData : regWdata;
      end
    end
  end

  // Read result held for the next capture
  always_ff @(posedge clk) begin
    if (srst) rdHold_reg <= DATA_RESET;
    else if (regRdStb) rdHold_reg <= regRdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output, changed on the falling link clock edge
  logic tdoBit;

  always_comb begin
    if (state_reg == ST_SHIFT_IR) tdoBit = irShift_reg[0];
    else if (chainOn) tdoBit = chain_reg[0];
    else if (selPath) tdoBit = selShift_reg[0];
    else tdoBit = bypass_reg;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tdo <= 1'b0;
      tdoOe <= 1'b0;
    end else if (tckFall) begin
      tdo <= tdoBit;
      tdoOe <= state_reg == ST_SHIFT_DR || state_reg == ST_SHIFT_IR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_UPDATE_ENTRY: assert property ((regWrStb || regRdStb) |->
    state_reg == ST_UPDATE_DR && $past(state_reg) != ST_UPDATE_DR)
    else $error("access outside Update-DR entry");

  AST_CHAIN_SIX: assert property ((regWrStb || regRdStb) |->
    chainSel_reg == CHAIN_TRACE && ir_reg == INST_INTEST)
    else $error("access while another chain selected");

  AST_ONLY_PORT: assert property ((regWrStb || regRdStb) |-> $past(tckRise))
    else $error("access without a link clock edge");

  AST_FIELDS: assert property ((regWrStb || regRdStb) |->
    regAddr == chainAddr && regWrStb == rwFlag)
    else $error("address or flag field mismatch");

  AST_RD_KEEP: assert property (regRdStb |-> !regWrStb && $stable(regWdata))
    else $error("read disturbed write data");

  AST_SHIFT_STEP: assert property (chainOn && inShDr |=>
    chain_reg[CHAIN_W-2:0] == $past(chain_reg[CHAIN_W-1:1]))
    else $error("chain did not shift by one");

  AST_CAPTURE_RD: assert property (chainOn && inCapDr |=>
    chainData == $past(rdHold_reg))
    else $error("capture did not load read value");
endmodule

// ==== dv/tmj_jtag_host.sv ====
// Test port host model driving the scan pins
module tmj_jtag_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdoLine
);
  timeunit 1ns;
  timeprecision 1ps;
  logic updWin = 1'b0;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One tck period; clock stands still between steps
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #100;
    q = tdoLine;
    tck = 1'b1;
    #100;
    tck = 1'b0;
  endtask
  task automatic toIdle();
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
  // Idle, scan n bits LSB first, Update, back to Idle
  task automatic scan(input logic ir, input int n, input logic [39:0] din,
      output logic [39:0] dout);
    logic q;
    dout = 40'h00_0000_0000;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    updWin = 1'b1;
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    updWin = 1'b0;
  endtask
endmodule

// ==== dv/trace_macrocell_jtag_access_tb_top.sv ====
// Bench for the trace register access chain
module trace_macrocell_jtag_access_tb_top
  import tmj_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic trstN = 1'b1;
  logic tdoLast = 1'b0;
  logic tck, tms, tdi, tdo, tdoOe, tdoLine, regWrStb, regRdStb;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata, regRdata;
  logic [CHAIN_W-1:0] dout;
  int failCount = 0;
  int compares = 0;
  int cycles = 0;
  int wrCount = 0;
  int rdCount = 0;
  int badStb = 0;
  localparam logic [DATA_W-1:0] RD_VAL = 32'hC3A5_5A3C;
  initial forever #12.5 clk = ~clk;
  // Read data valid only in the strobe cycle
  assign regRdata = regRdStb ? RD_VAL : ~RD_VAL;
  assign tdoLine = tdoOe ? tdo : ~tdoLast;
  tmj_access u_dut (.clk(clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi),
    .trstN(trstN), .tdo(tdo), .tdoOe(tdoOe), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));
  tmj_jtag_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdoLine(tdoLine));
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (tdoOe === 1'b1) tdoLast <= tdo;
    if (regWrStb === 1'b1) wrCount <= wrCount + 1;
    if (regRdStb === 1'b1) rdCount <= rdCount + 1;
    if ((regWrStb | regRdStb) === 1'b1 && !u_host.updWin) badStb <= badStb + 1;
    if (cycles == 20000) begin
      failCount++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One access scan, then strobe counts
  task automatic word(input logic [39:0] w, input int wr, input int rd);
    int w0;
    int r0;
    w0 = wrCount;
    r0 = rdCount;
    u_host.scan(1'b0, CHAIN_W, w, dout);
    chk(40'(wrCount - w0), 40'(wr));
    chk(40'(rdCount - r0), 40'(rd));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tRefused();
    word({1'b1, 7'h05, 32'h1234_5678}, 0, 0);
    u_host.scan(1'b1, IR_W, 40'(INST_INTEST), dout);
    chk(40'(dout[3:0]), 40'(IR_CAPTURE));
    word({1'b1, 7'h05, 32'h1234_5678}, 0, 0);
    chk(40'({regRdStb, regAddr, regWdata}), 40'h0);
    $display("test refused done");
  endtask
  task automatic tSelect();
    u_host.scan(1'b1, IR_W, 40'(INST_SCAN_N), dout);
    u_host.scan(1'b0, SEL_W, 40'(CHAIN_TRACE), dout);
    chk(40'(dout[3:0]), 40'(SEL_RESET));
    u_host.scan(1'b1, IR_W, 40'(INST_INTEST), dout);
    $display("test select done");
  endtask
  task automatic tWrite();
    for (int i = 0; i < 2; i++) begin
      logic [39:0] w;
      w = {1'b1, i ? 7'h7F : 7'h00, i ? 32'hFFFF_0001 : 32'h8000_00FE};
      word(w, 1, 0);
      chk(40'(regAddr), 40'(w[38:32]));
      chk(40'(regWdata), 40'(w[31:0]));
    end
    chk(40'(badStb), 40'h0);
    $display("test write done");
  endtask
  task automatic tRead();
    word({1'b0, 7'h2A, 32'hDEAD_BEEF}, 0, 1);
    chk(40'(regAddr), 40'h2A);
    chk(40'(regWdata), 40'hFFFF_0001);
    word({1'b1, 7'h11, 32'h0BAD_F00D}, 1, 0);
    chk(dout, {1'b0, 7'h2A, RD_VAL});
    chk(40'(badStb), 40'h0);
    $display("test read done");
  endtask
  task automatic tTrst();
    trstN = 1'b0;
    repeat (4) @(posedge clk);
    #1 trstN = 1'b1;
    u_host.toIdle();
    word({1'b1, 7'h33, 32'h5555_AAAA}, 0, 0);
    // Test reset must also have cleared the chain select
    u_host.scan(1'b1, IR_W, 40'(INST_SCAN_N), dout);
    u_host.scan(1'b0, SEL_W, 40'(CHAIN_TRACE), dout);
    chk(40'(dout[3:0]), 40'(SEL_RESET));
    $display("test test-reset done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 srst = 1'b0;
    repeat (4) @(posedge clk);
    // Keep every pin change just off the clock edge
    #1;
    u_host.toIdle();
    tRefused();
    tSelect();
    tWrite();
    tRead();
    tTrst();
    summarize();
  end
endmodule
